// *** design/fss_slave_sm.sv ***
// slave communication state machine with parameter directory front end
`include "fss_cfg.svh"
//------------------------------------------------------------------
//------------------------------------------------------------------
module fss_slave_sm #(
    parameter int          NUM_CHAN  = 4,
    parameter int          SUB_W     = 3,
    parameter int          IN_W      = 16,
    parameter int          OUT_W     = 16,
    parameter bit          ALT_RANGE = 1'b0,
    parameter logic [31:0] SAFE_OUT  = 32'h0000_0000,
    parameter logic [31:0] DEV_TYPE  = 32'h0000_0001,
    parameter logic [31:0] VENDOR    = 32'h0000_00A5, // arbitrary value
    parameter logic [31:0] SERIAL    = 32'h0000_0001
) (
    // clock, reset, enable
    input  wire logic                  clock_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    // state requests and setup checks
    input  wire logic                  req_valid_i,
    input  wire fss_pkg::fss_state_e   req_state_i,
    input  wire logic                  mbx_cfg_ok_i,
    input  wire logic                  pd_cfg_ok_i,
    input  wire logic                  dc_en_i,
    input  wire logic                  dc_ok_i,
    // state report
    output fss_pkg::fss_state_e        state_o,
    output logic                       ack_o,
    output logic                       err_o,
    output fss_pkg::fss_err_e          err_code_o,
    // mailbox
    input  wire logic                  mbx_valid_i,
    input  wire fss_pkg::fss_mbx_req_s mbx_req_i,
    output logic                       mbx_refused_o,
    output logic                       rsp_valid_o,
    output fss_pkg::fss_mbx_rsp_s      rsp_o,
    // firmware file access
    output logic                       fw_valid_o,
    output logic [31:0]                fw_data_o,
    // process data
    input  wire logic                  pd_valid_i,
    input  wire logic [OUT_W-1:0]      pd_out_i,
    input  wire logic [IN_W-1:0]       phys_in_i,
    output logic                       pd_refused_o,
    output logic [IN_W-1:0]            dpram_in_o,
    output logic [OUT_W-1:0]           phys_out_o,
    // non-volatile store
    output logic                       nvm_valid_o,
    output fss_pkg::fss_nvm_req_s      nvm_req_o,
    input  wire logic                  nvm_ack_i
);
    import fss_pkg::*;

    localparam int CW = $clog2(NUM_CHAN);
    localparam int AW = CW + 4 + SUB_W;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    generate
        if (NUM_CHAN < 2 || NUM_CHAN > 256 || (1 << CW) != NUM_CHAN) begin : g_bad_chan
            $error("fss_slave_sm: NUM_CHAN must be a power of two, 2 to 256");
        end
        if (SUB_W < 1 || SUB_W > 8 || AW > 16) begin : g_bad_sub
            $error("fss_slave_sm: SUB_W out of range");
        end
        if (IN_W > 32 || OUT_W > 32 || IN_W < 1 || OUT_W < 1) begin : g_bad_pd
            $error("fss_slave_sm: process data widths must be 1 to 32");
        end
    endgenerate

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        fss_state_e       st;
        logic             copy_pend;
        logic             out_seen;
        logic             ack;
        logic             err;
        fss_err_e         err_code;
        logic             refused;
        logic             pend_v;
        logic             pend_mem;
        logic             pend_err;
        logic [31:0]      pend_data;
        logic             rsp_v;
        fss_mbx_rsp_s     rsp;
        logic             pd_ref;
        logic             fw_v;
        logic [31:0]      fw_data;
        logic [IN_W-1:0]  dpram_in;
        logic [OUT_W-1:0] phys_out;
    } fss_top_s;

    fss_top_s r, n;

    // channel range base, chosen at build time
    localparam logic [15:0] CH_BASE  = ALT_RANGE ? `FSS_IDX_CHAN_ALT
                                                 : `FSS_IDX_CHAN_STD;
    localparam logic [15:0] CH_SPAN  = 16'(NUM_CHAN) * `FSS_CHAN_STRIDE;
    localparam logic [8:0]  SUB_LIM  = 9'(1 << SUB_W);
    localparam logic [7:0]  CH_COUNT = 8'(NUM_CHAN);

    // ------------------------------------------------------------
    // directory decode
    // ------------------------------------------------------------
    logic [15:0]   ch_off;
    logic          in_chan;
    logic [AW-1:0] mem_addr;
    logic          mem_we;
    logic [31:0]   mem_rdata;
    logic          nvm_busy;

    // channel n sits at base + n*0x10, each index holding the subindices
    always_comb begin
        ch_off   = mbx_req_i.index - CH_BASE;
        in_chan  = (mbx_req_i.index >= CH_BASE) && (ch_off < CH_SPAN)
                   && ({1'b0, mbx_req_i.sub} < SUB_LIM);
        mem_addr = {ch_off[CW+3:4], mbx_req_i.index[3:0], mbx_req_i.sub[SUB_W-1:0]};
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n         = r;
        n.ack     = 1'b0;
        n.refused = 1'b0;
        n.pd_ref  = 1'b0;
        n.fw_v    = 1'b0;
        n.pend_v  = 1'b0;
        n.rsp_v   = r.pend_v;
        mem_we    = 1'b0;

        // answer stage: two edges after the request
        if (r.pend_v) begin
            n.rsp.err  = r.pend_err;
            n.rsp.data = r.pend_mem ? mem_rdata : r.pend_data;
        end

        // -------- state transitions --------
        if (r.copy_pend) begin
            // inputs were copied at the previous edge; acknowledge now
            n.st        = FSS_SAFEOP;
            n.copy_pend = 1'b0;
            n.ack       = 1'b1;
        end else if (req_valid_i) begin
            n.ack = 1'b1;
            if (req_state_i == r.st) begin
                n.err = 1'b0;
            end else if (req_state_i == FSS_BOOT && r.st != FSS_INIT) begin
                n.ack      = 1'b0;
                n.err      = 1'b1;
                n.err_code = FSS_E_BOOT;
            end else begin
                case (r.st)
                    FSS_INIT: begin
                        if (req_state_i == FSS_BOOT) begin
                            n.st  = FSS_BOOT;
                            n.err = 1'b0;
                        end else if (req_state_i != FSS_PREOP) begin
                            n.ack      = 1'b0;
                            n.err      = 1'b1;
                            n.err_code = FSS_E_TRANS;
                        end else if (mbx_cfg_ok_i) begin
                            n.st  = FSS_PREOP;
                            n.err = 1'b0;
                        end else begin
                            n.ack      = 1'b0;
                            n.err      = 1'b1;
                            n.err_code = FSS_E_MBX;
                        end
                    end
                    FSS_PREOP: begin
                        if (req_state_i == FSS_INIT) begin
                            n.st  = FSS_INIT;
                            n.err = 1'b0;
                        end else if (req_state_i != FSS_SAFEOP) begin
                            n.ack      = 1'b0;
                            n.err      = 1'b1;
                            n.err_code = FSS_E_TRANS;
                        end else if (pd_cfg_ok_i && (!dc_en_i || dc_ok_i)) begin
                            // snapshot inputs first; the ack follows one edge later
                            n.ack       = 1'b0;
                            n.copy_pend = 1'b1;
                            n.dpram_in  = phys_in_i;
                            n.err       = 1'b0;
                        end else begin
                            n.ack      = 1'b0;
                            n.err      = 1'b1;
                            n.err_code = FSS_E_PD;
                        end
                    end
                    FSS_SAFEOP: begin
                        if (req_state_i == FSS_INIT || req_state_i == FSS_PREOP) begin
                            n.st  = req_state_i;
                            n.err = 1'b0;
                        end else if (req_state_i != FSS_OP) begin
                            n.ack      = 1'b0;
                            n.err      = 1'b1;
                            n.err_code = FSS_E_TRANS;
                        end else if (r.out_seen) begin
                            n.st  = FSS_OP;
                            n.err = 1'b0;
                        end else begin
                            n.ack      = 1'b0;
                            n.err      = 1'b1;
                            n.err_code = FSS_E_NO_OUT;
                        end
                    end
                    FSS_OP: begin
                        n.st  = req_state_i;
                        n.err = 1'b0;
                    end
                    FSS_BOOT: begin
                        if (req_state_i == FSS_INIT) begin
                            n.st  = FSS_INIT;
                            n.err = 1'b0;
                        end else begin
                            n.ack      = 1'b0;
                            n.err      = 1'b1;
                            n.err_code = FSS_E_TRANS;
                        end
                    end
                    default: begin
                        n.st = FSS_INIT;
                    end
                endcase
            end
        end

        // -------- process data --------
        if (pd_valid_i) begin
            if (r.st == FSS_SAFEOP || r.st == FSS_OP) begin
                n.dpram_in = phys_in_i;
                n.out_seen = 1'b1;
                if (r.st == FSS_OP) begin
                    n.phys_out = pd_out_i;
                end
            end else begin
                n.pd_ref = 1'b1;
            end
        end
        // outside op the pins fall back to the safe pattern
        if (n.st != FSS_OP) begin
            n.phys_out = SAFE_OUT[OUT_W-1:0];
        end
        if (n.st != FSS_SAFEOP && n.st != FSS_OP) begin
            n.out_seen = 1'b0;
        end

        // -------- mailbox --------
        if (mbx_valid_i) begin
            n.pend_mem  = 1'b0;
            n.pend_err  = 1'b0;
            n.pend_data = `FSS_DATA_RST;
            if (r.st == FSS_INIT) begin
                n.refused = 1'b1;
            end else if (r.st == FSS_BOOT) begin
                if (mbx_req_i.proto == FSS_FOE) begin
                    n.fw_v    = 1'b1;
                    n.fw_data = mbx_req_i.wdata;
                end else begin
                    n.refused = 1'b1;
                end
            end else if (mbx_req_i.proto != FSS_COE) begin
                // only directory traffic is served here
                n.pend_v   = 1'b1;
                n.pend_err = 1'b1;
            end else begin
                // directory open from pre-op onward
                n.pend_v = 1'b1;
                if (mbx_req_i.op == FSS_INFO) begin
                    n.pend_data = {CH_BASE, CH_COUNT, 8'(SUB_LIM - 9'h1)};
                end else if (in_chan) begin
                    if (mbx_req_i.op == FSS_WR) begin
                        if (nvm_busy) begin
                            n.pend_err = 1'b1;
                        end else begin
                            mem_we = 1'b1;
                        end
                    end else begin
                        n.pend_mem = 1'b1;
                    end
                end else if (mbx_req_i.op == FSS_WR) begin
                    n.pend_err = 1'b1;
                end else if (mbx_req_i.index == `FSS_IDX_DEVTYPE) begin
                    n.pend_data = DEV_TYPE;
                end else if (mbx_req_i.index == `FSS_IDX_IDENTITY
                             && mbx_req_i.sub == `FSS_SUB_VENDOR) begin
                    n.pend_data = VENDOR;
                end else if (mbx_req_i.index == `FSS_IDX_IDENTITY
                             && mbx_req_i.sub == `FSS_SUB_SERIAL) begin
                    n.pend_data = SERIAL;
                end else if (mbx_req_i.index[15:12] == `FSS_IDX_IN_PDO >> 12) begin
                    n.pend_data = 32'(r.dpram_in);
                end else if (mbx_req_i.index[15:12] == `FSS_IDX_OUT_PDO >> 12) begin
                    n.pend_data = 32'(r.phys_out);
                end else begin
                    n.pend_err = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            r          <= '0;
            r.st       <= FSS_INIT;
            r.err_code <= FSS_E_NONE;
            r.phys_out <= SAFE_OUT[OUT_W-1:0];
        end else if (ce_i) begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // parameter store and fail-safe writer
    // ------------------------------------------------------------
    fss_od_mem #(.AW(AW), .DW(32)) u_mem (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .we_i    (mem_we),
        .addr_i  (mem_addr),
        .wdata_i (mbx_req_i.wdata),
        .rdata_o (mem_rdata)
    );

    fss_nvm_commit #(.AW(AW)) u_nvm (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .wr_i        (mem_we),
        .wr_addr_i   (mem_addr),
        .wr_data_i   (mbx_req_i.wdata),
        .busy_o      (nvm_busy),
        .nvm_valid_o (nvm_valid_o),
        .nvm_req_o   (nvm_req_o),
        .nvm_ack_i   (nvm_ack_i)
    );

    // ------------------------------------------------------------
    // outputs from the state record; the non-volatile port comes straight from u_nvm
    // ------------------------------------------------------------
    assign state_o       = r.st;
    assign ack_o         = r.ack;
    assign err_o         = r.err;
    assign err_code_o    = r.err_code;
    assign mbx_refused_o = r.refused;
    assign rsp_valid_o   = r.rsp_v;
    assign rsp_o         = r.rsp;
    assign fw_valid_o    = r.fw_v;
    assign fw_data_o     = r.fw_data;
    assign pd_refused_o  = r.pd_ref;
    assign dpram_in_o    = r.dpram_in;
    assign phys_out_o    = r.phys_out;
endmodule : fss_slave_sm

// *** pkg/fss_cfg.svh ***
// offsets, index ranges and fixed values for the slave state machine
`ifndef FSS_CFG_SVH
`define FSS_CFG_SVH

// ---------------------------------------------------------------
// directory index ranges
// ---------------------------------------------------------------
`define FSS_IDX_IDENT     16'h1000
`define FSS_IDX_DEVTYPE   16'h1000
`define FSS_IDX_IDENTITY  16'h1018
`define FSS_SUB_VENDOR    8'h01
`define FSS_SUB_SERIAL    8'h04
`define FSS_IDX_CHAN_ALT  16'h4000
`define FSS_IDX_IN_PDO    16'h6000
`define FSS_IDX_OUT_PDO   16'h7000
`define FSS_IDX_CHAN_STD  16'h8000
`define FSS_RANGE_NIB     4'hF
`define FSS_CHAN_STRIDE   16'h0010
`define FSS_SUB_MAX       8'hFF

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define FSS_DATA_RST      32'h0000_0000

`endif

// *** pkg/fss_pkg.sv ***
// shared types of the slave state machine
package fss_pkg;

    // communication states
    typedef enum logic [2:0] {
        FSS_INIT   = 3'h1,
        FSS_PREOP  = 3'h2,
        FSS_BOOT   = 3'h3,
        FSS_SAFEOP = 3'h4,
        FSS_OP     = 3'h5
    } fss_state_e;

    // mailbox protocols
    typedef enum logic [1:0] {
        FSS_COE   = 2'h0,
        FSS_FOE   = 2'h1,
        FSS_OTHER = 2'h2
    } fss_proto_e;

    // directory operations
    typedef enum logic [1:0] {
        FSS_RD   = 2'h0,
        FSS_WR   = 2'h1,
        FSS_INFO = 2'h2
    } fss_op_e;

    // transition error codes
    typedef enum logic [2:0] {
        FSS_E_NONE   = 3'h0,
        FSS_E_MBX    = 3'h1,
        FSS_E_PD     = 3'h2,
        FSS_E_TRANS  = 3'h3,
        FSS_E_BOOT   = 3'h4,
        FSS_E_NO_OUT = 3'h5
    } fss_err_e;

    // non-volatile writer states
    typedef enum logic [1:0] {
        FSS_NV_IDLE = 2'h0,
        FSS_NV_DATA = 2'h1,
        FSS_NV_MARK = 2'h2
    } fss_nv_e;

    typedef struct packed {
        fss_proto_e  proto;
        fss_op_e     op;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [31:0] wdata;
    } fss_mbx_req_s;

    typedef struct packed {
        logic        err;
        logic [31:0] data;
    } fss_mbx_rsp_s;

    typedef struct packed {
        logic        commit;
        logic [15:0] addr;
        logic [31:0] data;
    } fss_nvm_req_s;

endpackage : fss_pkg

// *** design/fss_od_mem.sv ***
// channel parameter store with registered read data
module fss_od_mem #(
    parameter int AW = 9,
    parameter int DW = 32
) (
    // clock and reset
    input  wire logic          clock_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    // access port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_r [2**AW];
    logic [DW-1:0] rdata_r;

    // array has no reset; contents are restored from non-volatile store by firmware
    always_ff @(posedge clock_i) begin
        if (ce_i && we_i) begin
            mem_r[addr_i] <= wdata_i;
        end
    end

    // read data leaves a register, one edge after the address
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rdata_r <= '0;
        end else if (ce_i) begin
            rdata_r <= mem_r[addr_i];
        end
    end

    assign rdata_o = rdata_r;
endmodule : fss_od_mem

// *** design/fss_nvm_commit.sv ***
// fail-safe two-step writer toward non-volatile storage
module fss_nvm_commit #(
    parameter int AW = 9
) (
    // clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    // write events from the directory
    input  wire logic                 wr_i,
    input  wire logic [AW-1:0]        wr_addr_i,
    input  wire logic [31:0]          wr_data_i,
    output logic                      busy_o,
    // storage port
    output logic                      nvm_valid_o,
    output fss_pkg::fss_nvm_req_s     nvm_req_o,
    input  wire logic                 nvm_ack_i
);
    import fss_pkg::*;

    typedef struct packed {
        fss_nv_e      st;
        logic         busy;
        logic         valid;
        fss_nvm_req_s req;
    } fss_nv_s;

    fss_nv_s r, n;

    // payload first, commit marker second: a crash between them keeps the old value
    always_comb begin
        n = r;
        case (r.st)
            FSS_NV_IDLE: begin
                if (wr_i) begin
                    n.st    = FSS_NV_DATA;
                    n.busy  = 1'b1;
                    n.valid = 1'b1;
                    n.req   = '{commit: 1'b0, addr: 16'(wr_addr_i), data: wr_data_i};
                end
            end
            FSS_NV_DATA: begin
                if (nvm_ack_i) begin
                    n.st         = FSS_NV_MARK;
                    n.req.commit = 1'b1;
                end
            end
            FSS_NV_MARK: begin
                if (nvm_ack_i) begin
                    n.st    = FSS_NV_IDLE;
                    n.busy  = 1'b0;
                    n.valid = 1'b0;
                end
            end
            default: begin
                n.st = FSS_NV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            r <= '{st: FSS_NV_IDLE, busy: 1'b0, valid: 1'b0, req: '0};
        end else if (ce_i) begin
            r <= n;
        end
    end

    assign busy_o      = r.busy;
    assign nvm_valid_o = r.valid;
    assign nvm_req_o   = r.req;
endmodule : fss_nvm_commit

// *** tb/fss_slave_sva.sv ***
// assertions on the ports of the slave state machine
module fss_slave_sva import fss_pkg::*; #(parameter int IN_W = 16, parameter int OUT_W = 16) (
    // watched ports
    input wire logic clock_i, rst_i, ce_i, req_valid_i, mbx_cfg_ok_i, err_o, ack_o,
    input wire fss_state_e req_state_i, state_o,
    input wire fss_err_e err_code_o,
    input wire logic mbx_valid_i, mbx_refused_o, rsp_valid_o, pd_valid_i, pd_refused_o,
    input wire fss_mbx_req_s mbx_req_i,
    input wire logic [OUT_W-1:0] pd_out_i, phys_out_o,
    input wire logic [IN_W-1:0] phys_in_i, dpram_in_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    chk_init_refuse: assert property (ce_i && mbx_valid_i && state_o == FSS_INIT |=> mbx_refused_o)
        else $error("init mailbox not refused");
    chk_preop_mbx: assert property (ce_i && mbx_valid_i && state_o == FSS_PREOP |=> !mbx_refused_o ##1 rsp_valid_o)
        else $error("preop mailbox not answered");
    chk_preop_pd: assert property (ce_i && pd_valid_i && state_o == FSS_PREOP |=> pd_refused_o)
        else $error("preop process data not refused");
    chk_mbx_check: assert property (ce_i && req_valid_i && state_o == FSS_INIT && req_state_i == FSS_PREOP && !mbx_cfg_ok_i |=> state_o == FSS_INIT && err_code_o == FSS_E_MBX)
        else $error("mailbox check skipped");
    chk_boot_entry: assert property (ce_i && req_valid_i && req_state_i == FSS_BOOT && state_o != FSS_INIT && state_o != FSS_BOOT |=> state_o != FSS_BOOT)
        else $error("boot entered from wrong state");
    chk_boot_only_foe: assert property (ce_i && mbx_valid_i && state_o == FSS_BOOT && mbx_req_i.proto != FSS_FOE |=> mbx_refused_o)
        else $error("boot accepted other mailbox");
    chk_safe_hold: assert property (state_o != FSS_OP |-> phys_out_o == '0)
        else $error("outputs not safe");
    chk_in_update: assert property (ce_i && pd_valid_i && state_o == FSS_SAFEOP |=> dpram_in_o == $past(phys_in_i))
        else $error("inputs not updated");
    chk_out_apply: assert property (ce_i && pd_valid_i && !req_valid_i && state_o == FSS_OP |=> phys_out_o == $past(pd_out_i))
        else $error("outputs not applied");
    chk_fail_keeps: assert property ($rose(err_o) |-> $stable(state_o) && !ack_o)
        else $error("failed request moved state");
endmodule : fss_slave_sva
bind fss_slave_sm fss_slave_sva #(.IN_W(IN_W), .OUT_W(OUT_W)) fss_slave_sva_i (.*);

// *** tb/fss_nvm_model.sv ***
// storage side model: acknowledges each non-volatile request after a delay
module fss_nvm_model #(parameter int DLY = 2) (
    input  wire logic clock_i, rst_i, nvm_valid_i,
    output logic      nvm_ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt_r;
    // one-cycle ack DLY+1 cycles after valid rises; a slow part keeps the writer busy longer
    always_ff @(posedge clock_i) begin
        cnt_r <= (rst_i || !nvm_valid_i || nvm_ack_o) ? 0 : cnt_r + 1;
        nvm_ack_o <= !rst_i && nvm_valid_i && !nvm_ack_o && cnt_r == DLY;
    end
endmodule : fss_nvm_model

// *** tb/tb.sv ***
// self-checking bench for the slave state machine
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fss_pkg::*;
    logic clock_i, rst_i, req_valid_i, mbx_cfg_ok_i, pd_cfg_ok_i, mbx_valid_i, pd_valid_i;
    logic nvm_ack_i, ack_o, err_o, mbx_refused_o, rsp_valid_o, fw_valid_o, pd_refused_o;
    logic nvm_valid_o, f_ref, f_fw, f_rsp, f_c0, f_c1, f_ack, dc_en_i = 0, dc_ok_i = 0;
    fss_state_e req_state_i, state_o;
    fss_err_e err_code_o;
    fss_mbx_req_s mbx_req_i;
    fss_mbx_rsp_s rsp_o;
    fss_nvm_req_s nvm_req_o;
    logic [31:0] fw_data_o;
    logic [15:0] pd_out_i, phys_in_i, dpram_in_o, phys_out_o;
    int err_count = 0;
    int n_compared = 0;
    fss_slave_sm fss_slave_sm_i (.ce_i(1'h1), .*);
    fss_nvm_model fss_nvm_model_i (.clock_i, .rst_i, .nvm_valid_i(nvm_valid_o), .nvm_ack_o(nvm_ack_i));
    initial begin
        clock_i = 0;
        forever #20 clock_i = ~clock_i;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // state request pulse, then room for the extra copy edge
    task automatic req(input fss_state_e s);
        req_state_i = s;
        req_valid_i = 1;
        f_ack = 0;
        repeat (3) begin
            @(negedge clock_i) if (req_valid_i) req_valid_i = 0;
            f_ack |= ack_o;
        end
    endtask : req
    task automatic mbx(input fss_proto_e p, input fss_op_e o, input logic [15:0] ix,
                       input logic [7:0] sb, input logic [31:0] wd);
        mbx_req_i = '{p, o, ix, sb, wd};
        mbx_valid_i = 1;
        {f_ref, f_fw, f_rsp, f_c0, f_c1} = '0;
        repeat (12) begin
            @(negedge clock_i) if (mbx_valid_i) mbx_valid_i = 0;
            f_ref |= mbx_refused_o; f_fw |= fw_valid_o; f_rsp |= rsp_valid_o;
            f_c0 |= nvm_valid_o && !nvm_req_o.commit && nvm_req_o.addr == 16'h0081 && nvm_req_o.data == wd;
            f_c1 |= nvm_valid_o && nvm_req_o.commit;
        end
    endtask : mbx
    task automatic pd(input logic [15:0] o, input logic [15:0] i);
        {pd_out_i, phys_in_i, pd_valid_i, f_ref} = {o, i, 2'h2};
        repeat (2) begin
            @(negedge clock_i) pd_valid_i = 0;
            f_ref |= pd_refused_o;
        end
    endtask : pd
    task automatic t_init();
        chk(state_o, FSS_INIT);
        mbx(FSS_COE, FSS_RD, 16'h1000, 8'h00, 32'h0); chk(f_ref, 1'h1);
        pd(16'h0000, 16'h0000); chk(f_ref, 1'h1);
        req(FSS_PREOP); chk({state_o, err_code_o}, {FSS_INIT, FSS_E_MBX});
        req(FSS_OP); chk({err_code_o, f_ack}, {FSS_E_TRANS, 1'h0});
        req(FSS_BOOT); chk({state_o, f_ack}, {FSS_BOOT, 1'h1});
        mbx(FSS_FOE, FSS_WR, 16'h0000, 8'h00, 32'h1234_5678); chk({f_fw, fw_data_o}, {1'h1, 32'h1234_5678});
        mbx(FSS_COE, FSS_RD, 16'h1000, 8'h00, 32'h0); chk(f_ref, 1'h1);
        req(FSS_INIT);
        $display("init and boot test done");
    endtask : t_init
    task automatic t_pre();
        mbx_cfg_ok_i = 1; // mailbox channels set up while in init
        req(FSS_PREOP); chk({state_o, err_o}, {FSS_PREOP, 1'h0});
        mbx(FSS_COE, FSS_RD, 16'h1000, 8'h00, 32'h0); chk({f_ref, f_rsp, rsp_o}, {2'h1, 33'h1});
        mbx(FSS_COE, FSS_INFO, 16'h8000, 8'h00, 32'h0); chk(rsp_o.data, 32'h8000_0407);
        mbx(FSS_COE, FSS_WR, 16'h8010, 8'h01, 32'hA5A5_0F0F); chk({f_c0, f_c1, rsp_o.err}, 3'h6);
        mbx(FSS_COE, FSS_RD, 16'h8010, 8'h01, 32'h0); chk(rsp_o.data, 32'hA5A5_0F0F);
        pd(16'h0000, 16'h0000); chk(f_ref, 1'h1);
        req(FSS_BOOT); chk({state_o, err_code_o}, {FSS_PREOP, FSS_E_BOOT});
        $display("pre-operational test done");
    endtask : t_pre
    task automatic t_run();
        pd_cfg_ok_i = 1; // process data channels set up in pre-op
        phys_in_i = 16'h3C5A;
        {dc_en_i, dc_ok_i} = 2'h2; // clock sync in use, setup wrong
        req(FSS_SAFEOP); chk({state_o, err_code_o}, {FSS_PREOP, FSS_E_PD});
        dc_ok_i = 1;
        req(FSS_SAFEOP); chk({state_o, dpram_in_o}, {FSS_SAFEOP, 16'h3C5A});
        chk(f_ack, 1'h1);
        req(FSS_OP); chk({state_o, err_code_o}, {FSS_SAFEOP, FSS_E_NO_OUT});
        pd(16'hBEEF, 16'h1111); chk({phys_out_o, dpram_in_o}, 32'h0000_1111);
        req(FSS_OP); chk(state_o, FSS_OP);
        pd(16'hBEEF, 16'h2222); chk(phys_out_o, 16'hBEEF);
        mbx(FSS_COE, FSS_RD, 16'h7000, 8'h00, 32'h0); chk(rsp_o.data, 32'h0000_BEEF);
        req(FSS_INIT); chk({state_o, phys_out_o}, {FSS_INIT, 16'h0000});
        $display("operational test done");
    endtask : t_run
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        rst_i = 1;
        {req_valid_i, mbx_valid_i, pd_valid_i, mbx_cfg_ok_i, pd_cfg_ok_i} = '0;
        {req_state_i, mbx_req_i, pd_out_i, phys_in_i} = {FSS_INIT, 60'h0, 32'h0};
        repeat (6) @(negedge clock_i);
        rst_i = 0;
        t_init();
        t_pre();
        t_run();
        end_of_test();
    end
endmodule : tb
